// File: design/cantm_map.svh
// register offsets, fields and reset values of the can timing block
`ifndef CANTM_MAP_SVH
`define CANTM_MAP_SVH
`define CANTM_OFF_ERRCNT 12'h000
`define CANTM_OFF_TIMING1 12'h004
`define CANTM_OFF_MBW2 12'h008
`define CANTM_OFF_MBW3 12'h00C
`define CANTM_OFF_ERRINJ 12'h010
`define CANTM_OFF_TQSTAT 12'h014
`define CANTM_SJW_HI 7
`define CANTM_SJW_LO 6
`define CANTM_BRP_HI 5
`define CANTM_BRP_LO 0
`define CANTM_EID_HI 15
`define CANTM_EID_LO 10
`define CANTM_RTR_BIT 9
`define CANTM_RB1_BIT 8
`define CANTM_RB0_BIT 4
`define CANTM_DLC_HI 3
`define CANTM_DLC_LO 0
`define CANTM_MBW2_MASK 16'hFE0F
`define CANTM_TIMING1_MASK 16'h00FF
`define CANTM_RESET16 16'h0000
`define CANTM_HTRANS_NONSEQ 2'h2
`define CANTM_HSIZE_WORD 3'h2
`endif

// File: design/cantm_pkg.sv
// types shared by the can timing block
`default_nettype none
package cantm_pkg;
    typedef enum logic [1:0] {
        CANTM_IDLE = 2'h0,
        CANTM_DATA = 2'h1
    } cantm_phase_t;
endpackage : cantm_pkg
`default_nettype wire

// File: design/cantm_regs.sv
// can error counters, bit timing and message buffer words behind ahb-lite
// Behaviour
// - read-only word, tx and rx error counts
// - jump width is field plus one quanta
// - quantum is two times prescaler plus one
// - upper timing byte reads zero, reset zero
// - word two low nibble holds length code
// - word three holds data bytes 0 and 1
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cantm_map.svh"
module cantm_regs
    import cantm_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int PRESC_W = 6
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_hsel,
    input wire logic [11:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_tx_err_inc,
    input wire logic i_rx_err_inc,
    input wire logic i_err_clear,
    input wire logic i_rx_wr,
    input wire logic [3:0] i_rx_dlc,
    input wire logic [7:0] i_rx_byte0,
    input wire logic [7:0] i_rx_byte1,
    output logic [2:0] o_sync_jump_width,
    output logic o_tq_pulse
);
    initial begin
        if (CNT_W != 8 || PRESC_W != 6) begin
            $error("cantm_regs: field widths are fixed by the word layout");
        end
    end

    typedef struct packed {
        cantm_phase_t phase;
        logic [11:0] addr;
        logic wr;
        logic [7:0] tx_error_counter;
        logic [7:0] rx_error_counter;
        logic [7:0] timing1;
        logic [15:0] mbw2;
        logic [15:0] mbw3;
        logic [31:0] rdata;
        logic [15:0] tq_count;
    } cantm_st_t;

    cantm_st_t st_r;
    cantm_st_t st_nxt;
    logic tq_pulse;

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////////
    cantm_tq_gen #(
        .PRESC_W(PRESC_W)
    ) u_tq (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_presc(st_r.timing1[`CANTM_BRP_HI:`CANTM_BRP_LO]),
        .o_tq_pulse(tq_pulse)
    );

    ////////////////////////////////////////////////////////////////////////
    logic addr_ok;
    logic take;
    // only whole-word transfers are served; narrower ones are ignored
    assign take = i_hsel && i_hready && (i_htrans == `CANTM_HTRANS_NONSEQ) &&
        (i_hsize == `CANTM_HSIZE_WORD);

    always_comb begin
        st_nxt = st_r;
        addr_ok = 1'b0;
        if (tq_pulse) begin
            st_nxt.tq_count = st_r.tq_count + 16'h0001;
        end
        // counters saturate; engine events feed them
        if (i_err_clear) begin
            st_nxt.tx_error_counter = '0;
            st_nxt.rx_error_counter = '0;
        end else begin
            if (i_tx_err_inc) begin
                st_nxt.tx_error_counter = sat_inc(st_r.tx_error_counter);
            end
            if (i_rx_err_inc) begin
                st_nxt.rx_error_counter = sat_inc(st_r.rx_error_counter);
            end
        end
        // data phase write commits here
        if (st_r.phase == CANTM_DATA && st_r.wr) begin
            if (st_r.addr == `CANTM_OFF_TIMING1) begin
                // only the low byte is writable
                st_nxt.timing1 = i_hwdata[7:0];
            end else if (st_r.addr == `CANTM_OFF_MBW2) begin
                // reserved and unimplemented bits forced zero
                st_nxt.mbw2 = i_hwdata[15:0] & `CANTM_MBW2_MASK;
            end else if (st_r.addr == `CANTM_OFF_MBW3) begin
                st_nxt.mbw3 = i_hwdata[15:0];
            end
        end
        if (i_rx_wr) begin
            st_nxt.mbw2[`CANTM_DLC_HI:`CANTM_DLC_LO] = i_rx_dlc;
            // byte 0 low, byte 1 high
            st_nxt.mbw3 = {i_rx_byte1, i_rx_byte0};
        end
        st_nxt.phase = CANTM_IDLE;
        if (take) begin
            st_nxt.phase = CANTM_DATA;
            st_nxt.addr = i_haddr;
            st_nxt.wr = i_hwrite;
            st_nxt.rdata = '0;
            // reads see a write that commits on this same edge
            if (i_haddr == `CANTM_OFF_ERRCNT) begin
                // tx count high byte, rx count low
                st_nxt.rdata = {16'h0000, st_nxt.tx_error_counter,
                    st_nxt.rx_error_counter};
                addr_ok = 1'b1;
            end else if (i_haddr == `CANTM_OFF_TIMING1) begin
                st_nxt.rdata = {24'h000000, st_nxt.timing1};
                addr_ok = 1'b1;
            end else if (i_haddr == `CANTM_OFF_MBW2) begin
                st_nxt.rdata = {16'h0000, st_nxt.mbw2};
                addr_ok = 1'b1;
            end else if (i_haddr == `CANTM_OFF_MBW3) begin
                st_nxt.rdata = {16'h0000, st_nxt.mbw3};
                addr_ok = 1'b1;
            end else if (i_haddr == `CANTM_OFF_TQSTAT) begin
                st_nxt.rdata = {16'h0000, st_nxt.tq_count};
                addr_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            st_r.phase <= CANTM_IDLE;
            st_r.addr <= '0;
            st_r.wr <= 1'b0;
            st_r.tx_error_counter <= 8'h00;
            st_r.rx_error_counter <= 8'h00;
            st_r.timing1 <= 8'h00;
            st_r.mbw2 <= `CANTM_RESET16;
            st_r.mbw3 <= `CANTM_RESET16;
            st_r.rdata <= 32'h00000000;
            st_r.tq_count <= `CANTM_RESET16;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_hrdata = st_r.rdata;
    // zero wait states keep the slave trivial
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_tq_pulse = tq_pulse;
    // width is field value plus one
    assign o_sync_jump_width = {1'b0, st_r.timing1[`CANTM_SJW_HI:`CANTM_SJW_LO]}
        + 3'h1;

    ////////////////////////////////////////////////////////////////////////
    sequence s_data_write;
        st_r.phase == CANTM_DATA && st_r.wr;
    endsequence

    sequence s_write_timing;
        st_r.phase == CANTM_DATA && st_r.wr &&
            st_r.addr == `CANTM_OFF_TIMING1 && !i_rx_wr;
    endsequence

    chk_errcnt_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        take && !i_hwrite && i_haddr == `CANTM_OFF_ERRCNT |=>
        o_hrdata[15:8] == st_r.tx_error_counter &&
        o_hrdata[7:0] == st_r.rx_error_counter &&
        o_hrdata[31:16] == 16'h0000)
        else $error("error counter read wrong");

    // jump width range 1 to 4
    chk_sjw_range: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_sync_jump_width >= 3'h1 && o_sync_jump_width <= 3'h4)
        else $error("jump width out of range");

    chk_sjw_write: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        s_write_timing |=> o_sync_jump_width ==
        {1'b0, $past(i_hwdata[7:6])} + 3'h1)
        else $error("jump width not updated");

    chk_timing_upper: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        take && i_haddr == `CANTM_OFF_TIMING1 |=> o_hrdata[31:8] == 24'h0)
        else $error("timing upper byte not zero");

    chk_rx_dlc: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_rx_wr |=> st_r.mbw2[3:0] == $past(i_rx_dlc))
        else $error("length code not stored");

    chk_rx_bytes: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_rx_wr |=> st_r.mbw3 == {$past(i_rx_byte1), $past(i_rx_byte0)})
        else $error("data bytes misplaced");

    chk_rsv_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        st_r.mbw2[8] == 1'b0 && st_r.mbw2[7:4] == 4'h0)
        else $error("reserved bits set");

    chk_tx_inc: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_tx_err_inc && !i_err_clear && st_r.tx_error_counter != 8'hFF |=>
        st_r.tx_error_counter == $past(st_r.tx_error_counter) + 8'h01)
        else $error("tx counter did not count");

    chk_tq_period: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        tq_pulse && st_nxt.timing1[`CANTM_BRP_HI:`CANTM_BRP_LO] == 6'h00 |=>
        !tq_pulse ##1 tq_pulse)
        else $error("quantum period wrong");

    chk_unmapped_zero: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        take && !addr_ok |=> o_hrdata == 32'h00000000)
        else $error("unmapped read not zero");

    chk_timing_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        take && i_haddr == `CANTM_OFF_TIMING1 |=> o_hrdata[7:0] == st_r.timing1)
        else $error("timing read wrong");

    chk_timing_store: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        s_data_write ##0 st_r.addr == `CANTM_OFF_TIMING1 |=>
        st_r.timing1 == $past(i_hwdata[7:0]))
        else $error("timing write lost");

    chk_errcnt_ro: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        s_data_write ##0 (st_r.addr == `CANTM_OFF_ERRCNT &&
        !i_tx_err_inc && !i_rx_err_inc && !i_err_clear) |=>
        $stable(st_r.tx_error_counter) && $stable(st_r.rx_error_counter))
        else $error("error counters written by bus");

    chk_err_clear: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_err_clear |=> st_r.tx_error_counter == 8'h00 &&
        st_r.rx_error_counter == 8'h00)
        else $error("error counters not cleared");

    chk_rx_inc: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_rx_err_inc && !i_err_clear && st_r.rx_error_counter != 8'hFF |=>
        st_r.rx_error_counter == $past(st_r.rx_error_counter) + 8'h01)
        else $error("rx counter did not count");

    chk_tx_sat: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        st_r.tx_error_counter == 8'hFF && !i_err_clear |=>
        st_r.tx_error_counter == 8'hFF)
        else $error("tx counter wrapped");

    chk_reset_clear: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        !$past(i_rstn) |-> st_r.timing1 == 8'h00 &&
        st_r.tx_error_counter == 8'h00 && st_r.rx_error_counter == 8'h00)
        else $error("state not cleared by reset");

    chk_mbw2_store: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        s_data_write ##0 (st_r.addr == `CANTM_OFF_MBW2 && !i_rx_wr) |=>
        st_r.mbw2 == ($past(i_hwdata[15:0]) & `CANTM_MBW2_MASK))
        else $error("word two write wrong");

    chk_mbw3_store: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        s_data_write ##0 (st_r.addr == `CANTM_OFF_MBW3 && !i_rx_wr) |=>
        st_r.mbw3 == $past(i_hwdata[15:0]))
        else $error("word three write wrong");

    chk_rx_keep_id: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_rx_wr && !(st_r.phase == CANTM_DATA && st_r.wr) |=>
        st_r.mbw2[15:4] == $past(st_r.mbw2[15:4]))
        else $error("receive disturbed identifier bits");

    chk_tq_count: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        tq_pulse |=> st_r.tq_count == $past(st_r.tq_count) + 16'h0001)
        else $error("quantum count wrong");
endmodule : cantm_regs
`default_nettype wire

// File: design/cantm_tq_gen.sv
// time quantum enable divider from the module clock
`timescale 1ns/1ps
`default_nettype none
`include "cantm_map.svh"
module cantm_tq_gen
    import cantm_pkg::*;
#(
    parameter int PRESC_W = 6
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [PRESC_W-1:0] i_presc,
    output logic o_tq_pulse
);
    initial begin
        if (PRESC_W < 1 || PRESC_W > 16) begin
            $error("cantm_tq_gen: bad PRESC_W");
        end
    end

    typedef struct packed {
        logic [PRESC_W:0] cnt;
        logic pulse;
    } cantm_tq_st_t;

    cantm_tq_st_t st_r;
    cantm_tq_st_t st_nxt;
    logic [PRESC_W:0] last;

    assign last = {i_presc, 1'b1};

    always_comb begin
        st_nxt = st_r;
        st_nxt.pulse = 1'b0;
        if (st_r.cnt >= last) begin
            st_nxt.cnt = '0;
            st_nxt.pulse = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_tq_pulse = st_r.pulse;

    chk_tq_spacing: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_tq_pulse |=> !o_tq_pulse)
        else $error("tq pulse back to back");
endmodule : cantm_tq_gen
`default_nettype wire

// File: testbench/cantm_engine_model.sv
// protocol engine side model: error events and received frames
`timescale 1ns/1ps
`default_nettype none
module cantm_engine_model (
    input wire logic i_sys_clk,
    output logic o_tx_err_inc,
    output logic o_rx_err_inc,
    output logic o_err_clear,
    output logic o_rx_wr,
    output logic [3:0] o_rx_dlc,
    output logic [7:0] o_rx_byte0,
    output logic [7:0] o_rx_byte1
);
    initial begin
        {o_err_clear, o_rx_err_inc, o_tx_err_inc, o_rx_wr} = 4'h0;
        {o_rx_dlc, o_rx_byte1, o_rx_byte0} = 20'h5A5A5;
    end
    // kind 0 tx, 1 rx, 2 clear; quiet cycle after each
    task automatic event_pulse(input int kind);
        @(posedge i_sys_clk);
        {o_err_clear, o_rx_err_inc, o_tx_err_inc} <= 3'(3'h1 << kind);
        @(posedge i_sys_clk);
        {o_err_clear, o_rx_err_inc, o_tx_err_inc} <= 3'h0;
        @(posedge i_sys_clk);
    endtask : event_pulse
    task automatic frame(input logic [3:0] d, input logic [7:0] b0,
                         input logic [7:0] b1);
        @(posedge i_sys_clk);
        o_rx_wr <= 1'b1;
        {o_rx_dlc, o_rx_byte1, o_rx_byte0} <= {d, b1, b0};
        @(posedge i_sys_clk);
        o_rx_wr <= 1'b0;
        // released lines must not look like the last frame
        {o_rx_dlc, o_rx_byte1, o_rx_byte0} <= ~{d, b1, b0};
        @(posedge i_sys_clk);
    endtask : frame
endmodule : cantm_engine_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the can timing register block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q, u, v;
    logic hrdy, hresp, tq, txi, rxi, clr, rxw;
    logic [3:0] data_length_code;
    logic [7:0] b0, b1;
    logic [2:0] sync_jump_width;
    int bad_count = 0;
    int checks = 0;
    int tx_m, rx_m, k, p, tq_m;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (rstn !== 1'b1) tq_m <= 0;
        else if (tq === 1'b1) tq_m <= tq_m + 1;
    end
    cantm_regs cantm_regs_inst (.i_sys_clk(clk), .i_rstn(rstn),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
        .o_hresp(hresp), .i_tx_err_inc(txi), .i_rx_err_inc(rxi),
        .i_err_clear(clr), .i_rx_wr(rxw), .i_rx_dlc(data_length_code),
        .i_rx_byte0(b0), .i_rx_byte1(b1), .o_sync_jump_width(sync_jump_width),
        .o_tq_pulse(tq));
    cantm_engine_model eng (.i_sys_clk(clk), .o_tx_err_inc(txi),
        .o_rx_err_inc(rxi), .o_err_clear(clr), .o_rx_wr(rxw),
        .o_rx_dlc(data_length_code), .o_rx_byte0(b0), .o_rx_byte1(b1));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask : bus
    // cycles between two quantum pulses, skipping a stale first gap
    task automatic period(output int n);
        int c;
        c = 0;
        while (tq !== 1'b1 && c < 300) begin
            @(posedge clk);
            c++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tq !== 1'b1 && n < 300);
    endtask : period
    ////////////////////////////////////////////////////////////////////
    initial begin
        #250000;
        bad_count++;
        print_verdict();
    end
    initial begin
        q = $urandom(12);
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            bus(1'b0, 12'(a * 4), 32'h0, q);
            check(q, 32'h0);
            check({30'h0, hrdy, hresp}, 32'h2);
        end
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            u = $urandom;
            if (i < 4) u[7:6] = 2'(i);
            if (i < 2) u[5:0] = (i == 0) ? 6'h00 : 6'h3F;
            bus(1'b1, 12'h004, u, q);
            bus(1'b0, 12'h004, 32'h0, q);
            check(q, u & 32'h000000FF);
            check(32'(sync_jump_width), 32'(u[7:6]) + 32'h1);
            period(p);
            period(p);
            check(32'(p), 32'(2 * (u[5:0] + 1)));
        end
        bus(1'b1, 12'h014, u, q);
        bus(1'b0, 12'h014, 32'h0, q);
        check(q, 32'(tq_m) & 32'h0000FFFF);
        $display("test bit timing done");
        tx_m = 0;
        rx_m = 0;
        for (int j = 0; j < 280; j++) begin
            k = (j < 30) ? int'($urandom % 2) : 0;
            eng.event_pulse(k);
            if (k == 0) tx_m = (tx_m < 255) ? tx_m + 1 : 255;
            else rx_m++;
            if (j == 29 || j == 279) begin
                bus(1'b1, 12'h000, 32'hFFFF, q);
                bus(1'b0, 12'h000, 32'h0, q);
                check(q, 32'(tx_m * 256 + rx_m));
            end
        end
        eng.event_pulse(2);
        bus(1'b0, 12'h000, 32'h0, q);
        check(q, 32'h0);
        $display("test error counters done");
        for (int i = 0; i < 4; i++) begin
            u = $urandom;
            bus(1'b1, 12'h008, u, q);
            bus(1'b0, 12'h008, 32'h0, q);
            check(q, u & 32'h0000FE0F);
            bus(1'b1, 12'h00C, u, q);
            bus(1'b0, 12'h00C, 32'h0, q);
            check(q, u & 32'h0000FFFF);
            v = $urandom;
            eng.frame(v[3:0], v[15:8], v[23:16]);
            bus(1'b0, 12'h008, 32'h0, q);
            check(q, (u & 32'h0000FE00) | 32'(v[3:0]));
            bus(1'b0, 12'h00C, 32'h0, q);
            check(q, {16'h0, v[23:16], v[15:8]});
        end
        bus(1'b1, 12'h010, u, q);
        bus(1'b0, 12'h010, 32'h0, q);
        check(q, 32'h0);
        $display("test message buffer done");
        eng.event_pulse(0);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            bus(1'b0, 12'(a * 4), 32'h0, q);
            check(q, 32'h0);
        end
        $display("test second reset done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
